// *** vdp_map.vh ***
// Register map, field layout, reset values and timing for the motor loop.
// Assumes a 50 MHz core clock and a 32-bit APB register port.
`ifndef VDP_MAP_VH
`define VDP_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define VDP_OFF_CTRL     8'h00
`define VDP_OFF_VGAIN    8'h04
`define VDP_OFF_VMULT    8'h08
`define VDP_OFF_DGAIN    8'h0C
`define VDP_OFF_PWR      8'h10
`define VDP_OFF_VEL      8'h14
`define VDP_OFF_DSPD     8'h18
`define VDP_OFF_DIST     8'h1C
`define VDP_OFF_VELQ     8'h20
`define VDP_OFF_STAT     8'h24

// ----------------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------------
`define VDP_CTRL_RESTORE 0
`define VDP_CTRL_STOP    1

// ----------------------------------------------------------------------
// Factory defaults
// ----------------------------------------------------------------------
`define VDP_DEF_VP       8'h02
`define VDP_DEF_VI       8'h01
`define VDP_DEF_VD       8'h01
`define VDP_DEF_VMULT    16'h000A
`define VDP_DEF_DP       8'h01
`define VDP_DEF_DI       8'h00
`define VDP_DEF_DD       8'h00
`define VDP_DEF_DACC     8'h01

// ----------------------------------------------------------------------
// Power range and arithmetic scaling
// ----------------------------------------------------------------------
`define VDP_PWR_MAX      32'sd100
`define VDP_GAIN_SHIFT   4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define VDP_TICK_NS      1600000
`define VDP_CLK_NS       20

`endif

// *** vdp_loop.v ***
// Two-motor velocity loop with an outer distance loop and APB registers.
// Assumes encoder tick pulses synchronous to I_CLK, one cycle per tick.
//
// Behaviour
// [R01] A basic tick of 1.6 ms is the timebase for all loop work.
// [R02] One velocity loop step runs after multiplier basic ticks.
// [R03] Velocity loop set holds proportional, integral, derivative gains and multiplier.
// [R04] Direct power command bypasses the loop; 100 is full power.
// [R05] Velocity query reports encoder ticks counted per loop period.
// [R06] Distance move ramps velocity setpoint until distance covered, then stops.
// [R07] Acceleration step is added to commanded speed each loop until target.
// [R08] Distance set defaults to 1, 0, 0, 1 after reset or restore.
// [R09] Restore reloads velocity and distance sets with factory values.
// [R10] Loop state reads 1 while a move runs, 0 once completed.
// [R11] Host should wait for loop state 0 before the next distance move.
// [R12] Host should pick a multiplier giving 50 to 250 ticks per loop.
// [R13] Loop output is clamped to full forward and full reverse power.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "vdp_map.vh"

module vdp_loop #(
  parameter integer BASIC_TICK_CYC = `VDP_TICK_NS / `VDP_CLK_NS
) (
  // Clock, reset and enable
  input  wire        I_CLK,
  input  wire        I_RST,
  input  wire        I_CE,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output wire        O_PREADY,
  output reg         O_PSLVERR,
  // Encoders
  input  wire [1:0]  I_ENC_TICK,
  input  wire [1:0]  I_ENC_REV,
  // H-bridge power, signed, -100 to 100
  output reg  [7:0]  O_PWR_A,
  output reg  [7:0]  O_PWR_B,
  // Loop state
  output wire        O_BUSY
);

  // --------------------------------------------------------------------
  // States and constants
  // --------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PWR  = 4'b0010;
  localparam [3:0] ST_VEL  = 4'b0100;
  localparam [3:0] ST_DIST = 4'b1000;
  localparam [16:0] BT_LAST = BASIC_TICK_CYC[16:0] - 17'h0_001;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Limit a loop result to the motor power range
  function [7:0] clamp_pwr;
    input signed [31:0] v;
    begin
      if (v > `VDP_PWR_MAX) begin
        clamp_pwr = 8'h64;
      end else if (v < -`VDP_PWR_MAX) begin
        clamp_pwr = 8'h9C;
      end else begin
        clamp_pwr = v[7:0];
      end
    end
  endfunction

  // Saturating 16-bit add for the integrator
  function [15:0] sat_add16;
    input signed [15:0] a;
    input signed [16:0] b;
    reg   signed [17:0] s;
    begin
      s = {{2{a[15]}}, a} + {b[16], b};
      if (s > 18'sd32767) begin
        sat_add16 = 16'h7FFF;
      end else if (s < -18'sd32768) begin
        sat_add16 = 16'h8000;
      end else begin
        sat_add16 = s[15:0];
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg        [16:0] basic_cnt;
  reg        [15:0] loop_cnt;
  reg        [7:0]  vp, vi, vd, dp, di, dd, dacc;
  reg        [15:0] vmult;
  reg        [23:0] dist_goal;
  reg        [15:0] dist_spd;
  reg               ready_q;
  reg        [3:0]  state    [0:1];
  reg signed [15:0] enc_cnt  [0:1];
  reg signed [15:0] vel_q    [0:1];
  reg signed [15:0] sp       [0:1];
  reg signed [15:0] integ    [0:1];
  reg signed [16:0] prev_err [0:1];
  reg        [23:0] trav     [0:1];
  reg        [7:0]  ramp     [0:1];
  reg        [7:0]  pwr      [0:1];

  // Loop step values, per motor
  reg signed [16:0] next_err   [0:1];
  reg        [15:0] next_integ [0:1];
  reg        [7:0]  next_pwr   [0:1];
  reg        [23:0] next_trav  [0:1];
  reg        [7:0]  next_ramp  [0:1];
  reg signed [15:0] next_sp    [0:1];
  reg               next_done  [0:1];

  wire basic_tick = (basic_cnt == BT_LAST);
  wire loop_tick  = basic_tick && (loop_cnt + 16'h0001 >= vmult);
  wire access     = I_PSEL && I_PENABLE;
  wire wr_now     = access && I_PWRITE && ready_q;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  integer     m;

  // Loop state reflects a distance move running on either motor
  assign O_BUSY   = (state[0] == ST_DIST) || (state[1] == ST_DIST); // [R10]
  assign O_PREADY = ready_q;

  // --------------------------------------------------------------------
  // Loop arithmetic
  // --------------------------------------------------------------------
  // Velocity step and distance ramp, computed each cycle for both motors
  always @* begin : loop_math
    reg signed [17:0] derr;
    reg signed [31:0] u;
    reg        [15:0] meas_mag;
    reg        [7:0]  tgt_mag;
    reg        [8:0]  ramp_sum;
    reg        [23:0] rem;
    reg        [31:0] cap;
    reg        [7:0]  sp_mag;
    integer           m;
    m        = 0;
    derr     = 18'sd0;
    u        = 32'sd0;
    meas_mag = 16'h0000;
    tgt_mag  = 8'h00;
    ramp_sum = 9'h000;
    rem      = 24'h00_0000;
    cap      = 32'h0000_0000;
    sp_mag   = 8'h00;
    for (m = 0; m < 2; m = m + 1) begin
      // PID on ticks per loop period
      next_err[m]   = {sp[m][15], sp[m]} - {enc_cnt[m][15], enc_cnt[m]};
      derr          = {next_err[m][16], next_err[m]} -
                      {prev_err[m][16], prev_err[m]};
      next_integ[m] = sat_add16(integ[m], next_err[m]);
      u = $signed({1'b0, vp}) * next_err[m]
        + $signed({1'b0, vi}) * $signed(next_integ[m])
        + $signed({1'b0, vd}) * derr;                       // [R03]
      next_pwr[m]   = clamp_pwr(u >>> `VDP_GAIN_SHIFT);     // [R13]
      // Distance covered so far
      meas_mag     = enc_cnt[m][15] ? (16'h0000 - enc_cnt[m]) : enc_cnt[m];
      next_trav[m] = trav[m] + {8'h00, meas_mag};
      next_done[m] = (next_trav[m] >= dist_goal);           // [R06]
      // Acceleration ramp toward the target speed
      tgt_mag  = dist_spd[8*m+7] ? (8'h00 - dist_spd[8*m +: 8])
                                 : dist_spd[8*m +: 8];
      ramp_sum = {1'b0, ramp[m]} + {1'b0, dacc};
      next_ramp[m] = (ramp_sum >= {1'b0, tgt_mag}) ? tgt_mag
                                                   : ramp_sum[7:0]; // [R07]
      // Proportional cap on remaining distance slows the final approach
      rem    = next_done[m] ? 24'h00_0000 : (dist_goal - next_trav[m]);
      cap    = dp * rem;
      sp_mag = (cap < {24'h00_0000, next_ramp[m]}) ? cap[7:0]
                                                   : next_ramp[m];
      next_sp[m] = dist_spd[8*m+7] ? (16'h0000 - {8'h00, sp_mag})
                                   : {8'h00, sp_mag};
    end
  end

  // --------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------
  // Read data and address check for the current access
  always @* begin
    rd_hit = 1'b1;
    if (I_PADDR == `VDP_OFF_CTRL) begin
      rd_mux = 32'h0000_0000;
    end else if (I_PADDR == `VDP_OFF_VGAIN) begin
      rd_mux = {8'h00, vd, vi, vp};
    end else if (I_PADDR == `VDP_OFF_VMULT) begin
      rd_mux = {16'h0000, vmult};
    end else if (I_PADDR == `VDP_OFF_DGAIN) begin
      rd_mux = {dacc, dd, di, dp};
    end else if (I_PADDR == `VDP_OFF_PWR) begin
      rd_mux = {16'h0000, pwr[1], pwr[0]};
    end else if (I_PADDR == `VDP_OFF_VEL) begin
      rd_mux = {sp[1], sp[0]};
    end else if (I_PADDR == `VDP_OFF_DSPD) begin
      rd_mux = {16'h0000, dist_spd};
    end else if (I_PADDR == `VDP_OFF_DIST) begin
      rd_mux = {8'h00, dist_goal};
    end else if (I_PADDR == `VDP_OFF_VELQ) begin
      rd_mux = {vel_q[1], vel_q[0]};                        // [R05]
    end else if (I_PADDR == `VDP_OFF_STAT) begin
      rd_mux = {20'h0_0000, state[1], state[0], 3'b000, O_BUSY}; // [R10]
    end else begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Sequential logic
  // --------------------------------------------------------------------
  // Timebase, loop steps, commands and the bus slave
  always @(posedge I_CLK) begin
    if (I_RST) begin
      basic_cnt <= 17'h0_0000;
      loop_cnt  <= 16'h0000;
      vp        <= `VDP_DEF_VP;
      vi        <= `VDP_DEF_VI;
      vd        <= `VDP_DEF_VD;
      vmult     <= `VDP_DEF_VMULT;
      dp        <= `VDP_DEF_DP;                             // [R08]
      di        <= `VDP_DEF_DI;
      dd        <= `VDP_DEF_DD;
      dacc      <= `VDP_DEF_DACC;
      dist_goal <= 24'h00_0000;
      dist_spd  <= 16'h0000;
      ready_q   <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
      O_PWR_A   <= 8'h00;
      O_PWR_B   <= 8'h00;
      for (m = 0; m < 2; m = m + 1) begin
        state[m]    <= ST_IDLE;
        enc_cnt[m]  <= 16'h0000;
        vel_q[m]    <= 16'h0000;
        sp[m]       <= 16'h0000;
        integ[m]    <= 16'h0000;
        prev_err[m] <= 17'h0_0000;
        trav[m]     <= 24'h00_0000;
        ramp[m]     <= 8'h00;
        pwr[m]      <= 8'h00;
      end
    end else if (I_CE) begin
      // Basic tick divider and loop multiplier
      basic_cnt <= basic_tick ? 17'h0_0000 : basic_cnt + 17'h0_0001; // [R01]
      if (loop_tick) begin
        loop_cnt <= 16'h0000;                               // [R02]
      end else if (basic_tick) begin
        loop_cnt <= loop_cnt + 16'h0001;
      end
      for (m = 0; m < 2; m = m + 1) begin
        // Encoder ticks per loop period; a tick on the step edge is kept
        if (loop_tick) begin
          vel_q[m]   <= enc_cnt[m];                         // [R05]
          enc_cnt[m] <= !I_ENC_TICK[m] ? 16'h0000 :
                        (I_ENC_REV[m] ? 16'hFFFF : 16'h0001);
        end else if (I_ENC_TICK[m]) begin
          enc_cnt[m] <= I_ENC_REV[m] ? enc_cnt[m] - 16'h0001
                                     : enc_cnt[m] + 16'h0001;
        end
        // One loop step per motor
        if (loop_tick) begin
          case (state[m])
            ST_VEL: begin
              pwr[m]      <= next_pwr[m];
              integ[m]    <= next_integ[m];
              prev_err[m] <= next_err[m];
            end
            ST_DIST: begin
              if (next_done[m]) begin
                state[m] <= ST_IDLE;                        // [R06]
                sp[m]    <= 16'h0000;
                pwr[m]   <= 8'h00;
              end else begin
                pwr[m]      <= next_pwr[m];
                integ[m]    <= next_integ[m];
                prev_err[m] <= next_err[m];
                trav[m]     <= next_trav[m];
                ramp[m]     <= next_ramp[m];                // [R07]
                sp[m]       <= next_sp[m];
              end
            end
            ST_PWR: begin
              pwr[m] <= pwr[m];                             // [R04]
            end
            default: begin
              pwr[m] <= 8'h00;
            end
          endcase
        end
        // Move commands from the bus override the loop step
        if (wr_now && I_PADDR == `VDP_OFF_PWR) begin
          state[m] <= ST_PWR;
          pwr[m]   <= clamp_pwr({{24{I_PWDATA[8*m+7]}},
                                 I_PWDATA[8*m +: 8]});      // [R04]
        end else if (wr_now && I_PADDR == `VDP_OFF_VEL) begin
          state[m]    <= ST_VEL;
          sp[m]       <= I_PWDATA[16*m +: 16];
          integ[m]    <= 16'h0000;
          prev_err[m] <= 17'h0_0000;
        end else if (wr_now && I_PADDR == `VDP_OFF_DIST) begin
          state[m]    <= ST_DIST;
          sp[m]       <= 16'h0000;
          trav[m]     <= 24'h00_0000;
          ramp[m]     <= 8'h00;
          integ[m]    <= 16'h0000;
          prev_err[m] <= 17'h0_0000;
        end else if (wr_now && I_PADDR == `VDP_OFF_CTRL &&
                     I_PWDATA[`VDP_CTRL_STOP]) begin
          state[m] <= ST_IDLE;
          sp[m]    <= 16'h0000;
          pwr[m]   <= 8'h00;
        end
      end
      // Parameter writes and restore
      if (wr_now) begin
        if (I_PADDR == `VDP_OFF_CTRL) begin
          if (I_PWDATA[`VDP_CTRL_RESTORE]) begin
            vp    <= `VDP_DEF_VP;                           // [R09]
            vi    <= `VDP_DEF_VI;
            vd    <= `VDP_DEF_VD;
            vmult <= `VDP_DEF_VMULT;
            dp    <= `VDP_DEF_DP;                           // [R08]
            di    <= `VDP_DEF_DI;
            dd    <= `VDP_DEF_DD;
            dacc  <= `VDP_DEF_DACC;
          end
        end else if (I_PADDR == `VDP_OFF_VGAIN) begin
          vp <= I_PWDATA[7:0];                              // [R03]
          vi <= I_PWDATA[15:8];
          vd <= I_PWDATA[23:16];
        end else if (I_PADDR == `VDP_OFF_VMULT) begin
          vmult <= I_PWDATA[15:0];                          // [R03]
        end else if (I_PADDR == `VDP_OFF_DGAIN) begin
          dp   <= I_PWDATA[7:0];
          di   <= I_PWDATA[15:8];
          dd   <= I_PWDATA[23:16];
          dacc <= I_PWDATA[31:24];
        end else if (I_PADDR == `VDP_OFF_DSPD) begin
          dist_spd <= I_PWDATA[15:0];
        end else if (I_PADDR == `VDP_OFF_DIST) begin
          dist_goal <= I_PWDATA[23:0];
        end
      end
      // Bus slave: one wait state, data and error captured before ready
      if (access && !ready_q) begin
        ready_q   <= 1'b1;
        O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rd_mux;
        O_PSLVERR <= !rd_hit;
      end else begin
        ready_q   <= 1'b0;
        O_PSLVERR <= 1'b0;
      end
      // Power outputs follow the loop result or the direct power command
      O_PWR_A <= pwr[0];
      O_PWR_B <= pwr[1];
    end
  end

endmodule

// *** vdp_loop_chk.sv ***
// Concurrent checks on the motor loop ports, bound to every vdp_loop.
// Assumes one clock domain, the register map header and I_CE high.
`timescale 1ns/1ps
`include "vdp_map.vh"

module vdp_loop_chk (
  // Clock and reset
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_CE,
  // APB
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Motor side
  input wire logic [7:0]  O_PWR_A,
  input wire logic [7:0]  O_PWR_B,
  input wire logic        O_BUSY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  wait_one_a: assert property (I_PSEL && I_PENABLE && !O_PREADY && I_CE
    ##1 I_CE |-> O_PREADY) else $error("bus answer late");
  ready_pulse_a: assert property (O_PREADY && I_CE |=> !O_PREADY)
    else $error("ready held too long");
  ready_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");

  // ----------------------------------------------------------------
  // Motor power and loop state
  // ----------------------------------------------------------------
  pwr_a_clamp_a: assert property ($signed(O_PWR_A) >= -8'sd100 &&
    $signed(O_PWR_A) <= 8'sd100) else $error("power A range");
  pwr_b_clamp_a: assert property ($signed(O_PWR_B) >= -8'sd100 &&
    $signed(O_PWR_B) <= 8'sd100) else $error("power B range");
  busy_start_a: assert property ($rose(O_BUSY) |-> $past(O_PREADY &&
    I_PWRITE && I_PADDR == `VDP_OFF_DIST))
    else $error("busy without move");
  stop_idle_a: assert property (O_PREADY && !O_PSLVERR && I_PWRITE &&
    I_PADDR == `VDP_OFF_CTRL && I_PWDATA[`VDP_CTRL_STOP] |->
    ##[1:3] (O_PWR_A == 8'h00 && O_PWR_B == 8'h00 && !O_BUSY))
    else $error("stop not idle");

  // Main scenarios reached
  cover property (O_PREADY && O_PSLVERR);
  cover property ($rose(O_BUSY));
  cover property ($fell(O_BUSY));
  cover property (O_PWR_A == 8'h64);
endmodule

bind vdp_loop vdp_loop_chk u_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_PWR_A(O_PWR_A), .O_PWR_B(O_PWR_B), .O_BUSY(O_BUSY));

// *** vdp_motor_model.sv ***
// Two motors with encoders; tick rate follows the power magnitude.
// Assumes signed power -100..100 and one clock shared with the loop.
`timescale 1ns/1ps

module vdp_motor_model (
  // Clock, reset and speed choice
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slow,
  // Power from the bridge side
  input  wire logic [7:0] i_pwr_a,
  input  wire logic [7:0] i_pwr_b,
  // Encoder pulses and direction
  output logic      [1:0] o_tick,
  output logic      [1:0] o_rev
);
  logic [8:0] acc_a;
  logic [8:0] acc_b;

  // A tick each time the summed magnitude passes the threshold
  function automatic logic [9:0] step(input logic [8:0] acc,
                                      input logic [7:0] p);
    logic [7:0] m;
    logic [8:0] s;
    logic [8:0] th;
    m = p[7] ? -p : p;
    s = acc + m;
    th = i_slow ? 9'd200 : 9'd100;
    step = (s >= th) ? {1'b1, s - th} : {1'b0, s};
  endfunction

  // Pulses change just after the edge; direction rides with them
  always @(posedge i_clk) begin
    if (i_rst) begin
      acc_a  <= 9'd0;
      acc_b  <= 9'd0;
      o_tick <= 2'b00;
      o_rev  <= 2'b00;
    end else begin
      {o_tick[0], acc_a} <= step(acc_a, i_pwr_a);
      {o_tick[1], acc_b} <= step(acc_b, i_pwr_b);
      o_rev <= {i_pwr_b[7], i_pwr_a[7]};
    end
  end
endmodule

// *** test_vdp_loop.sv ***
// Self-checking bench for the motor loop with the motor model.
// Assumes a 20-cycle basic tick and an APB master written here.
`timescale 1ns/1ps
`include "vdp_map.vh"

module test_vdp_loop;
  localparam integer TICK = 20;
  logic        clk, rst, psel, penable, pwrite, slow, e;
  logic        busy, pready, pslverr;
  logic [7:0]  paddr, pwr_a, pwr_b;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  tick, rev;
  integer      error_cnt, compares, k, m, ea;

  always #10 clk = ~clk;

  vdp_loop #(.BASIC_TICK_CYC(TICK)) uut (.I_CLK(clk), .I_RST(rst),
    .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ENC_TICK(tick),
    .I_ENC_REV(rev), .O_PWR_A(pwr_a), .O_PWR_B(pwr_b), .O_BUSY(busy));
  vdp_motor_model u_motor (.i_clk(clk), .i_rst(rst), .i_slow(slow),
    .i_pwr_a(pwr_a), .i_pwr_b(pwr_b), .o_tick(tick), .o_rev(rev));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task results;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; held until ready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n = n + 1;
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) chk(32'd0, 32'd1);
  endtask

  // Bounded wait for both power outputs
  task wait_pwr(input logic [7:0] a, input logic [7:0] b);
    k = 0;
    while ({pwr_b, pwr_a} !== {b, a} && k < 400) begin
      @(negedge clk);
      k = k + 1;
    end
    chk({16'h0000, pwr_b, pwr_a}, {16'h0000, b, a});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_defaults;
    apb(0, `VDP_OFF_VGAIN, 0);
    chk(q, 32'h0001_0102);
    apb(0, `VDP_OFF_VMULT, 0);
    chk(q, 32'h0000_000A);
    apb(0, `VDP_OFF_DGAIN, 0);
    chk(q, 32'h0100_0001);
    apb(0, `VDP_OFF_STAT, 0);
    chk(q & 32'h0000_0001, 32'h0000_0000);
  endtask

  task t_restore;
    apb(1, `VDP_OFF_VGAIN, 32'h0003_0405);
    apb(1, `VDP_OFF_VMULT, 32'h0000_0007);
    apb(1, `VDP_OFF_DGAIN, 32'h0402_0305);
    apb(0, `VDP_OFF_DGAIN, 0);
    chk(q, 32'h0402_0305);
    apb(1, `VDP_OFF_CTRL, 32'h0000_0001);
    t_defaults;
  endtask

  // Direct power, out-of-range values first, then a held setting
  task t_power;
    apb(1, `VDP_OFF_PWR, 32'h0000_807F);
    wait_pwr(8'h64, 8'h9C);
    apb(1, `VDP_OFF_PWR, 32'h0000_CE64);
    wait_pwr(8'h64, 8'hCE);
  endtask

  // Measured ticks per loop for several multipliers and motor speeds
  task t_vel;
    for (k = 0; k < 4; k = k + 1) begin
      m = k == 0 ? 10 : k == 1 ? 5 : k == 2 ? 1 : 4;
      slow <= (k == 3);
      apb(1, `VDP_OFF_VMULT, m);
      repeat (700) @(posedge clk);
      apb(0, `VDP_OFF_VELQ, 0);
      ea = TICK * m / (k == 3 ? 2 : 1);
      chk(q, {16'(-ea / 2), 16'(ea)});
    end
    slow <= 1'b0;
    wait_pwr(8'h64, 8'hCE);
  endtask

  // Distance move: ramp by the step, then stop on its own
  task t_dist;
    apb(1, `VDP_OFF_VMULT, 32'h0000_0001);
    apb(1, `VDP_OFF_DGAIN, 32'h0300_0001);
    apb(1, `VDP_OFF_DSPD, 32'h0000_1414);
    apb(1, `VDP_OFF_DIST, 32'h0000_0064);
    @(negedge clk);
    chk(busy, 1);
    apb(0, `VDP_OFF_STAT, 0);
    chk(q & 32'h0000_0FF1, 32'h0000_0881);
    repeat (22) @(posedge clk);
    apb(0, `VDP_OFF_VEL, 0);
    chk((q[15:0] === 16'd3 || q[15:0] === 16'd6) &&
        q[31:16] === q[15:0], 1);
    k = 0;
    while (busy !== 1'b0 && k < 40000) begin
      @(negedge clk);
      k = k + 1;
    end
    chk(busy, 0);
    apb(0, `VDP_OFF_STAT, 0);
    chk(q & 32'h0000_0FF1, 32'h0000_0110);
    chk({pwr_b, pwr_a}, 0);
  endtask

  // Stop in mid-move, then unmapped places
  task t_stop_refuse;
    apb(1, `VDP_OFF_DIST, 32'h00FF_FFFF);
    apb(1, `VDP_OFF_CTRL, 32'h0000_0002);
    apb(0, `VDP_OFF_STAT, 0);
    chk(q & 32'h0000_0FF1, 32'h0000_0110);
    apb(1, 8'h3C, 32'hFFFF_FFFF);
    chk(e, 1);
    apb(0, 8'h40, 0);
    chk({e, q[30:0]}, 32'h8000_0000);
    apb(0, `VDP_OFF_VMULT, 0);
    chk(q, 32'h0000_0001);
  endtask

  task t_reset;
    apb(1, `VDP_OFF_VGAIN, 32'h0000_0909);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    chk({pwr_b, pwr_a}, 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    slow = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_restore;
    t_power;
    t_vel;
    t_dist;
    t_stop_refuse;
    t_reset;
    results;
  end

  initial begin
    #(90000 * 20);
    error_cnt = error_cnt + 1;
    results;
  end
endmodule
